// ==== logic/flash_warm_reset_control.sv ====
// Warm reset sequencer for a serial flash: reset pin and shared data line 3.
// Operation
// - Reset low beyond minimum width reinitialises state within the hold period.
// - Without completed power-on, a qualified reset starts the full power-on sequence.
// - During reset abort work, float outputs, ignore commands, idle interface.
// - Software reset command works whatever the reset input level.
// - Reset ignored during power-up; held reset keeps device in reset.
// - Line 3 is reset when enabled and deselected long enough, or quad off.
// - In quad mode line 3 low is ignored for deselect time after select rises.
// - After a quad read, drive line 3 high before releasing it.
// - In quad mode, select low starting a command makes line 3 data, not reset.
`timescale 1ns/1ns
module flash_warm_reset_control #(
  parameter logic [15:0] POWER_UP_CYCLES = 16'h7530
) (
  input  wire logic core_clk,           // Free-running core clock, 100 MHz
  input  wire logic resetn,             // Asynchronous reset, active low
  input  wire logic sck,                // Serial link clock
  input  wire logic resetPinN,          // Dedicated reset pin, active low
  input  wire logic csN,                // Chip select pin, active low
  input  wire logic io3In,              // Data line 3 pin level
  input  wire logic line3ResetEnable,   // Line 3 reset enable bit
  input  wire logic quadMode,           // Quad mode bit
  input  wire logic porOk,              // Power-on initialisation completed correctly
  input  wire logic softResetCmd,       // Software reset command decoded, pulse
  input  wire logic quadReadDrive,      // Quad read is driving line 3 (core clock)
  input  wire logic readDataIo3,        // Line 3 read data bit (sck domain)
  output logic      warmResetQ,         // Warm register reinitialisation active
  output logic      fullPorQ,           // Full power-on sequence active
  output logic      resetActiveQ,       // Abort, float outputs, ignore commands
  output logic      selectAllowedQ,     // Chip select may be asserted
  output logic      softResetQ,         // Software reset request, pulse
  output logic      io3Out,             // Line 3 output value
  output logic      io3OutEnN           // Line 3 output enable, active low
);

  // ==========================================================================
  // Parameter check
  // ==========================================================================
  if (POWER_UP_CYCLES == 16'h0) begin : g_badPu
    $error("POWER_UP_CYCLES must be at least one");
  end

  // ==========================================================================
  // Pin synchronisation
  // ==========================================================================
  logic [2:0] pinSync;
  logic       resetPinS;
  logic       csS;
  logic       io3S;
  logic       readDriveSck;

  sync_two_flop #(.WIDTH(3), .RST_VAL(3'h7)) u_pinSync (
    .clk    (core_clk),
    .resetn (resetn),
    .d      ({resetPinN, csN, io3In}),
    .q      (pinSync)
  );

  sync_two_flop #(.WIDTH(1), .RST_VAL(1'h0)) u_driveSync (
    .clk    (sck),
    .resetn (resetn),
    .d      (quadReadDrive),
    .q      (readDriveSck)
  );

  assign resetPinS = pinSync[2];
  assign csS       = pinSync[1];
  assign io3S      = pinSync[0];

  // ==========================================================================
  // Line 3 role
  // ==========================================================================
  logic [15:0] csHighCntQ;
  logic [15:0] csHighCntD;
  logic        deselLong;
  logic        io3IsReset;
  logic        rstLow;

  assign csHighCntD = !csS ? 16'h0
                    : (csHighCntQ == flash_warm_reset_pkg::CNT_MAX ? csHighCntQ
                                                                     : csHighCntQ + 16'h1);
  // The deselect filter keeps the tail of a transfer from looking like a reset.
  assign deselLong  = csS && (csHighCntQ >= flash_warm_reset_pkg::DESEL_CYC);
  assign io3IsReset = !quadMode || (line3ResetEnable && deselLong);
  assign rstLow     = !resetPinS || (io3IsReset && !io3S);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      csHighCntQ <= 16'h0;
    end else begin
      csHighCntQ <= csHighCntD;
    end
  end

  // ==========================================================================
  // Reset sequencer
  // ==========================================================================
  flash_warm_reset_pkg::rst_state_e stateQ;
  flash_warm_reset_pkg::rst_state_e stateD;
  logic [15:0] cntQ;
  logic [15:0] cntD;
  logic [15:0] cntInc;
  flash_warm_reset_pkg::rst_state_e afterReset;

  assign cntInc     = (cntQ == flash_warm_reset_pkg::CNT_MAX) ? cntQ : cntQ + 16'h1;
  assign afterReset = rstLow ? flash_warm_reset_pkg::WAIT_HIGH
                             : flash_warm_reset_pkg::RECOVER;

  always_comb begin
    stateD = stateQ;
    unique case (stateQ)
      flash_warm_reset_pkg::POWER_UP,
      flash_warm_reset_pkg::FULL_POR: begin
        // A low reset here is not acted on; only its level at the end counts.
        if (cntQ >= POWER_UP_CYCLES - 16'h1) begin
          stateD = afterReset;
        end
      end
      flash_warm_reset_pkg::IDLE: begin
        if (rstLow) begin
          stateD = flash_warm_reset_pkg::QUALIFY;
        end
      end
      flash_warm_reset_pkg::QUALIFY: begin
        if (!rstLow) begin
          stateD = flash_warm_reset_pkg::IDLE;
        end else if (cntQ >= flash_warm_reset_pkg::RP_CYC) begin
          stateD = porOk ? flash_warm_reset_pkg::HOLD
                         : flash_warm_reset_pkg::FULL_POR;
        end
      end
      flash_warm_reset_pkg::HOLD: begin
        // The full hold runs even if the host releases early.
        if (cntQ >= flash_warm_reset_pkg::RPH_CYC - 16'h1) begin
          stateD = afterReset;
        end
      end
      flash_warm_reset_pkg::WAIT_HIGH: begin
        if (!rstLow) begin
          stateD = flash_warm_reset_pkg::RECOVER;
        end
      end
      flash_warm_reset_pkg::RECOVER: begin
        // A new low before the setup time has passed is not taken.
        if (cntQ >= flash_warm_reset_pkg::RS_CYC - 16'h1) begin
          stateD = flash_warm_reset_pkg::IDLE;
        end
      end
    endcase
  end

  assign cntD = (stateD != stateQ) ? 16'h0 : cntInc;

  // ==========================================================================
  // Output decode
  // ==========================================================================
  logic resetActiveD;
  logic selectAllowedD;
  logic [1:0] disCntQ;
  logic [1:0] disCntD;
  logic readDriving;
  logic enNextN;

  assign resetActiveD   = (stateD == flash_warm_reset_pkg::POWER_UP)
                       || (stateD == flash_warm_reset_pkg::HOLD)
                       || (stateD == flash_warm_reset_pkg::FULL_POR)
                       || (stateD == flash_warm_reset_pkg::WAIT_HIGH);
  assign selectAllowedD = (stateD == flash_warm_reset_pkg::IDLE)
                       || (stateD == flash_warm_reset_pkg::QUALIFY)
                       || ((stateD == flash_warm_reset_pkg::RECOVER)
                           && (cntD >= flash_warm_reset_pkg::RH_CYC));
  assign readDriving    = !csS && quadReadDrive;
  // Keep driving for the disable interval after deselect so the line ends high.
  assign disCntD        = readDriving ? flash_warm_reset_pkg::DIS_CYC
                        : (disCntQ != 2'h0 ? disCntQ - 2'h1 : 2'h0);
  assign enNextN        = resetActiveD || !(readDriving || disCntQ != 2'h0);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stateQ         <= flash_warm_reset_pkg::POWER_UP;
      cntQ           <= 16'h0;
      warmResetQ     <= 1'b0;
      fullPorQ       <= 1'b0;
      resetActiveQ   <= 1'b1;
      selectAllowedQ <= 1'b0;
      softResetQ     <= 1'b0;
      disCntQ        <= 2'h0;
      io3OutEnN      <= 1'b1;
    end else begin
      stateQ         <= stateD;
      cntQ           <= cntD;
      warmResetQ     <= (stateD == flash_warm_reset_pkg::HOLD);
      fullPorQ       <= (stateD == flash_warm_reset_pkg::FULL_POR);
      resetActiveQ   <= resetActiveD;
      selectAllowedQ <= selectAllowedD;
      softResetQ     <= softResetCmd;
      disCntQ        <= disCntD;
      io3OutEnN      <= enNextN;
    end
  end

  // ==========================================================================
  // Link-side line 3 data
  // ==========================================================================
  // Deselect presets the bit high at once, so the sck domain needs no edge after
  // the frame to leave the line parked high.
  always_ff @(negedge sck or negedge resetn or posedge csN) begin
    if (!resetn) begin
      io3Out <= 1'b1;
    end else if (csN) begin
      io3Out <= 1'b1;
    end else begin
      io3Out <= readDriveSck ? readDataIo3 : 1'b1;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  logic [15:0] lowRunQ;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lowRunQ <= 16'h0;
    end else begin
      lowRunQ <= !rstLow ? 16'h0
               : (lowRunQ == flash_warm_reset_pkg::CNT_MAX ? lowRunQ : lowRunQ + 16'h1);
    end
  end

  property p_qualified;
    @(posedge core_clk) disable iff (!resetn)
      $rose(warmResetQ) |-> ($past(lowRunQ) > flash_warm_reset_pkg::RP_CYC);
  endproperty
  a_qualified: assert property (p_qualified) else $error("warm reset without qualified low");

  property p_holdLength;
    @(posedge core_clk) disable iff (!resetn)
      $fell(warmResetQ) |-> ($past(cntQ) == flash_warm_reset_pkg::RPH_CYC - 16'h1);
  endproperty
  a_holdLength: assert property (p_holdLength) else $error("hold period length wrong");

  property p_fullPor;
    @(posedge core_clk) disable iff (!resetn)
      $rose(fullPorQ) |-> !$past(porOk) && !warmResetQ;
  endproperty
  a_fullPor: assert property (p_fullPor) else $error("full power-on taken with porOk");

  property p_floatInReset;
    @(posedge core_clk) disable iff (!resetn)
      resetActiveQ |-> io3OutEnN && !selectAllowedQ;
  endproperty
  a_floatInReset: assert property (p_floatInReset) else $error("driving during reset");

  property p_softReset;
    @(posedge core_clk) disable iff (!resetn)
      softResetCmd |=> softResetQ;
  endproperty
  a_softReset: assert property (p_softReset) else $error("software reset lost");

  property p_powerUpIgnore;
    @(posedge core_clk) disable iff (!resetn)
      (stateQ == flash_warm_reset_pkg::POWER_UP) |=> !warmResetQ && !fullPorQ;
  endproperty
  a_powerUpIgnore: assert property (p_powerUpIgnore) else $error("reset taken in power-up");

  property p_quadOffReset;
    @(posedge core_clk) disable iff (!resetn)
      (stateQ == flash_warm_reset_pkg::IDLE) && !quadMode && !io3S
        |=> (stateQ == flash_warm_reset_pkg::QUALIFY);
  endproperty
  a_quadOffReset: assert property (p_quadOffReset) else $error("line 3 low not qualified");

  property p_deselFilter;
    @(posedge core_clk) disable iff (!resetn)
      quadMode && (!csS || csHighCntQ < flash_warm_reset_pkg::DESEL_CYC) |-> !io3IsReset;
  endproperty
  a_deselFilter: assert property (p_deselFilter) else $error("line 3 reset too early");

  property p_driveHigh;
    @(posedge core_clk) disable iff (!resetn)
      $rose(csS) && $past(readDriving) && !resetActiveQ |-> !io3OutEnN && io3Out;
  endproperty
  a_driveHigh: assert property (p_driveHigh) else $error("line 3 released before high");

  property p_shortPulse;
    @(posedge core_clk) disable iff (!resetn)
      (stateQ == flash_warm_reset_pkg::QUALIFY) && !rstLow
        |=> (stateQ == flash_warm_reset_pkg::IDLE) && !warmResetQ && !fullPorQ;
  endproperty
  a_shortPulse: assert property (p_shortPulse) else $error("short low pulse acted on");

  property p_selectRelease;
    @(posedge core_clk) disable iff (!resetn)
      $rose(selectAllowedQ)
        |-> ($past(stateQ) == flash_warm_reset_pkg::RECOVER)
            && ($past(cntQ) >= flash_warm_reset_pkg::RH_CYC - 16'h1);
  endproperty
  a_selectRelease: assert property (p_selectRelease) else $error("select allowed too early");

endmodule

// ==== logic/flash_warm_reset_pkg.sv ====
// Shared timing constants and state encoding for the flash warm reset controller.
package flash_warm_reset_pkg;

  // ==========================================================================
  // Clock and printed times
  // ==========================================================================
  localparam int CLK_PERIOD_NS             = 10;
  localparam int RESET_PULSE_WIDTH_NS      = 200;  // least
  localparam int RESET_HOLD_PERIOD_US      = 35;   // least
  localparam int RESET_SETUP_TIME_NS       = 50;   // least
  localparam int RESET_RELEASE_TO_SELECT_NS = 50;  // least
  localparam int DESELECT_TIME_NS          = 20;   // least
  localparam int OUTPUT_DISABLE_INTERVAL_NS = 20;  // longest

  // ==========================================================================
  // Derived cycle counts
  // ==========================================================================
  localparam logic [15:0] RP_CYC   =
    16'((RESET_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] RPH_CYC  =
    16'((RESET_HOLD_PERIOD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] RS_CYC   =
    16'((RESET_SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] RH_CYC   =
    16'((RESET_RELEASE_TO_SELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] DESEL_CYC =
    16'((DESELECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [1:0]  DIS_CYC  = 2'(OUTPUT_DISABLE_INTERVAL_NS / CLK_PERIOD_NS);
  localparam logic [15:0] CNT_MAX  = 16'hffff;

  // ==========================================================================
  // Sequencer states
  // ==========================================================================
  typedef enum logic [2:0] {
    POWER_UP,
    IDLE,
    QUALIFY,
    HOLD,
    FULL_POR,
    WAIT_HIGH,
    RECOVER
  } rst_state_e;

endpackage

// ==== logic/sync_two_flop.sv ====
// Two flip-flop level synchroniser with a parameterised width and reset value.
`timescale 1ns/1ns
module sync_two_flop #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,     // Destination clock
  input  wire logic             resetn,  // Asynchronous reset, active low
  input  wire logic [WIDTH-1:0] d,       // Asynchronous level in
  output logic      [WIDTH-1:0] q        // Synchronised level out
);

  logic [WIDTH-1:0] metaQ;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      metaQ <= RST_VAL;
      q     <= RST_VAL;
    end else begin
      metaQ <= d;
      q     <= metaQ;
    end
  end

endmodule

// ==== bench/spi_host_model.sv ====
// Host side model: chip select, reset pin, line 3 drive and the link clock.
`timescale 1ns/1ns
module spi_host_model (
  input  wire logic core_clk,   // Pacing clock
  output logic      sck,        // Link clock, still between frames
  output logic      csN,        // Chip select, active low
  output logic      resetPinN,  // Reset pin, active low
  output logic      io3DrvEn,   // Host drives line 3
  output logic      io3Drv,     // Host line 3 value
  output logic      rdBit       // Read data bit for the flash core
);
  initial begin
    sck = 1'b0;
    csN = 1'b1;
    resetPinN = 1'b1;
    io3DrvEn = 1'b0;
    io3Drv = 1'b1;
    rdBit = 1'b0;
  end
  task automatic sel(input logic v);
    @(negedge core_clk);
    csN = v;
  endtask
  task automatic pin(input logic v);
    @(negedge core_clk);
    resetPinN = v;
  endtask
  // Callers keep pulses far below the boot read maximum width.
  task automatic pulse(input bit onL3, input int low);
    repeat (int'(flash_warm_reset_pkg::RS_CYC) + 1) @(negedge core_clk);
    // The pulse goes either on line 3 or on the reset pin, never on both.
    io3DrvEn = onL3;
    io3Drv = !onL3;
    resetPinN = onL3;
    repeat (low) @(negedge core_clk);
    resetPinN = 1'b1;
    // Line 3 is driven high first so the pull-up never has to lift it.
    io3Drv = 1'b1;
    @(negedge core_clk);
    io3DrvEn = 1'b0;
  endtask
  task automatic clk_bit(input logic b);
    sck = !sck;
    rdBit = b;
    #7;
    sck = !sck;
    #8;
  endtask
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the flash warm reset controller.
`timescale 1ns/1ns
module testbench;
  logic core_clk, resetn, l3En, quadMode, porOk, softCmd, qrDrive;
  logic sck, csN, resetPinN, io3DrvEn, io3Drv, rdBit;
  logic warmResetQ, fullPorQ, resetActiveQ, selectAllowedQ, softResetQ;
  logic io3Out, io3OutEnN;
  wire  io3In;
  int   errors, n_compared, cycles;
  localparam logic [15:0] PU_CYCLES = 16'h0032;

  // Line 3 carries a pull-up, so a released line reads high.
  assign io3In = !io3OutEnN ? io3Out : (io3DrvEn ? io3Drv : 1'b1);

  spi_host_model i_host (.core_clk(core_clk), .sck(sck), .csN(csN),
    .resetPinN(resetPinN), .io3DrvEn(io3DrvEn), .io3Drv(io3Drv), .rdBit(rdBit));

  flash_warm_reset_control #(.POWER_UP_CYCLES(PU_CYCLES)) i_dut (
    .core_clk(core_clk), .resetn(resetn), .sck(sck), .resetPinN(resetPinN),
    .csN(csN), .io3In(io3In), .line3ResetEnable(l3En), .quadMode(quadMode),
    .porOk(porOk), .softResetCmd(softCmd), .quadReadDrive(qrDrive),
    .readDataIo3(rdBit), .warmResetQ(warmResetQ), .fullPorQ(fullPorQ),
    .resetActiveQ(resetActiveQ), .selectAllowedQ(selectAllowedQ),
    .softResetQ(softResetQ), .io3Out(io3Out), .io3OutEnN(io3OutEnN));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      end_of_test();
    end
  end

  task automatic wait_select();
    int k;
    k = 0;
    while (selectAllowedQ !== 1'b1 && k < 30) begin
      @(negedge core_clk);
      k++;
    end
    check("select allowed", selectAllowedQ, 1'b1);
  endtask

  // A low pulse, counting the cycles that the chosen hold output stands high.
  task automatic hw_reset(input bit onL3, input int low, input logic [15:0] expLen, input bit full);
    int n;
    n = 0;
    fork
      i_host.pulse(onL3, low);
      repeat (low + 3600) begin
        @(posedge core_clk);
        #1;
        if (full ? fullPorQ === 1'b1 : warmResetQ === 1'b1)
          n++;
        if (n == 10) begin
          check("abort active", resetActiveQ, 1'b1);
          check("select blocked", selectAllowedQ, 1'b0);
          check("line3 float", io3OutEnN, 1'b1);
          check("other hold", full ? warmResetQ : fullPorQ, 1'b0);
          i_host.sel(1'b1);
        end
      end
    join
    check("hold length", n[15:0], expLen);
    wait_select();
  endtask

  task automatic power_up_held();
    repeat (60) @(negedge core_clk);
    check("pu warm", warmResetQ, 1'b0);
    check("pu active", resetActiveQ, 1'b1);
    check("pu select", selectAllowedQ, 1'b0);
    i_host.pin(1'b1);
    wait_select();
  endtask

  task automatic soft_reset();
    @(negedge core_clk);
    softCmd = 1'b1;
    @(negedge core_clk);
    check("soft pulse", softResetQ, 1'b1);
    softCmd = 1'b0;
    @(negedge core_clk);
    check("soft end", softResetQ, 1'b0);
  endtask

  task automatic quad_read();
    logic [7:0] data;
    int k;
    data = 8'h5a;
    k = 0;
    i_host.sel(1'b0);
    qrDrive = 1'b1;
    while (io3OutEnN !== 1'b0 && k < 10) begin
      @(negedge core_clk);
      k++;
    end
    check("line3 enable", io3OutEnN, 1'b0);
    repeat (2) i_host.clk_bit(1'b1);
    for (int i = 7; i >= 0; i--) begin
      i_host.clk_bit(data[i]);
      check("line3 data", io3Out, data[i]);
    end
    i_host.sel(1'b1);
    #1;
    check("line3 high", io3Out, 1'b1);
    @(posedge core_clk);
    #1;
    check("line3 still driven", io3OutEnN, 1'b0);
    k = 0;
    while (io3OutEnN !== 1'b1 && k < 10) begin
      @(negedge core_clk);
      k++;
    end
    check("line3 released", io3OutEnN, 1'b1);
    qrDrive = 1'b0;
  endtask

  initial begin
    errors = 0;
    n_compared = 0;
    cycles = 0;
    resetn = 1'b0;
    l3En = 1'b0;
    quadMode = 1'b0;
    porOk = 1'b1;
    softCmd = 1'b0;
    qrDrive = 1'b0;
    i_host.pin(1'b0);
    repeat (6) @(negedge core_clk);
    resetn = 1'b1;
    power_up_held();
    soft_reset();
    hw_reset(1'b0, 10, 16'h0000, 1'b0);
    i_host.sel(1'b0);
    hw_reset(1'b0, 30, flash_warm_reset_pkg::RPH_CYC, 1'b0);
    i_host.sel(1'b0);
    hw_reset(1'b1, 30, flash_warm_reset_pkg::RPH_CYC, 1'b0);
    // Line 3 with select high, through every setting of the two mode bits.
    for (int m = 0; m < 4; m++) begin
      {quadMode, l3En} = 2'(m);
      hw_reset(1'b1, 30, (!quadMode || l3En) ? flash_warm_reset_pkg::RPH_CYC : 16'h0000,
               1'b0);
    end
    i_host.sel(1'b0);
    hw_reset(1'b1, 30, 16'h0000, 1'b0);
    i_host.sel(1'b1);
    porOk = 1'b0;
    hw_reset(1'b0, 30, PU_CYCLES, 1'b1);
    porOk = 1'b1;
    quad_read();
    end_of_test();
  end
endmodule
